// ==== cmx_cfg.svh ====
// Constants for the compare and move executor
`ifndef CMX_CFG_SVH
`define CMX_CFG_SVH
`define CMX_OFF_CTRL 12'h000
`define CMX_OFF_CMPA 12'h004
`define CMX_OFF_CMPB 12'h008
`define CMX_OFF_SRC 12'h00c
`define CMX_OFF_PTR 12'h010
`define CMX_OFF_DEST 12'h014
`define CMX_OFF_FLAGS 12'h018
`define CMX_OFF_LIMIT 12'h01c
`define CMX_CTRL_CMP_EXEC 0
`define CMX_CTRL_MOV_EXEC 1
`define CMX_CTRL_MOV_EDGE 2
`define CMX_CTRL_SRC_IND 3
`define CMX_CTRL_GO 4
`define CMX_FLAG_GREATER 0
`define CMX_FLAG_EQUAL 1
`define CMX_FLAG_LESS 2
`define CMX_FLAG_ERROR 3
`define CMX_ADDR_GREATER 16'd25505
`define CMX_ADDR_EQUAL 16'd25506
`define CMX_ADDR_LESS 16'd25507
`define CMX_MEM_LIMIT_RST 16'h1fff
`define CMX_WORD_RST 16'h0000
`endif

// ==== cmx_pkg.sv ====
// Types for the compare and move executor
package cmx_pkg;
	typedef logic [15:0] cmx_word_t;
	typedef enum logic [1:0] {CMX_IDLE = 2'b00, CMX_FETCH = 2'b01, CMX_EXEC = 2'b11} cmx_state_t;
endpackage : cmx_pkg

// ==== cmx_dm.sv ====
// Small data memory with registered read data
`timescale 1ns/1ps
module cmx_mem #(
	parameter int AW = 6
) (
	// Clock
	input wire logic pclk,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [15:0] wdata,
	// Read port
	input wire logic [AW-1:0] raddr,
	output logic [15:0] rdata
);
	logic [15:0] mem [0:(1<<AW)-1];
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : cmx_mem

// ==== cmx_bcd.sv ====
// BCD check and conversion of a four-digit pointer
`timescale 1ns/1ps
module cmx_bcd (
	// Pointer in
	input wire logic [15:0] bcd,
	// Result out
	output logic valid,
	output logic [15:0] bin
);
	always_comb begin
		valid = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (bcd[4*i +: 4] > 4'h9) begin
				valid = 1'b0;
			end
		end
		bin = 16'(bcd[15:12]) * 16'd1000 + 16'(bcd[11:8]) * 16'd100 + 16'(bcd[7:4]) * 16'd10 + 16'(bcd[3:0]);
	end
endmodule : cmx_bcd

// ==== cmx_top.sv ====
// Word compare and word copy execution with APB register access
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "cmx_cfg.svh"
module cmx_top #(
	parameter int MEM_AW = 6
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Flag outputs
	output logic greater_flag,
	output logic equal_flag,
	output logic less_flag,
	output logic error_flag,
	// Destination word
	output cmx_pkg::cmx_word_t dest_word
);
	import cmx_pkg::*;

	cmx_state_t state_q;
	cmx_word_t first_compare_word_q;
	cmx_word_t second_compare_word_q;
	cmx_word_t src_q;
	cmx_word_t ptr_q;
	cmx_word_t mem_limit_q;
	logic cmp_exec_q;
	logic mov_exec_q;
	logic mov_edge_q;
	logic src_ind_q;
	logic mov_prev_q;
	logic go_q;
	logic ptr_ok;
	cmx_word_t ptr_bin;
	logic [15:0] mem_rdata;
	logic mem_we;
	logic [MEM_AW-1:0] mem_waddr;
	cmx_word_t operand;
	logic ptr_bad;
	logic run_copy;

	logic wr_en;
	logic rd_setup;
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a[11:5] == 7'h00) && (a[1:0] == 2'b00);
	endfunction : mapped

	// Zero extension of a word into the bus width
	function automatic logic [31:0] zext(input cmx_word_t w);
		zext = {16'h0, w};
	endfunction : zext

	assign pslverr = psel & penable & ~mapped(paddr);

	// Control write and scan activity
	logic ctrl_wr;
	logic busy;
	assign ctrl_wr = wr_en && hit(paddr, `CMX_OFF_CTRL);
	assign busy = state_q != CMX_IDLE;

	// Memory load through the destination offset: index in bits 21:16, word in bits 15:0
	assign mem_we = wr_en && hit(paddr, `CMX_OFF_DEST) && pwdata[31];
	assign mem_waddr = pwdata[16+MEM_AW-1:16];

	cmx_bcd u_bcd (
		.bcd(ptr_q),
		.valid(ptr_ok),
		.bin(ptr_bin)
	);

	cmx_mem #(
		.AW(MEM_AW)
	) u_mem (
		.pclk(pclk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(pwdata[15:0]),
		.raddr(ptr_bin[MEM_AW-1:0]),
		.rdata(mem_rdata)
	);

	// Indirect pointer must be BCD and within the area
	assign ptr_bad = src_ind_q && (!ptr_ok || ptr_bin > mem_limit_q || ptr_bin >= 16'(1 << MEM_AW));
	assign operand = src_ind_q ? mem_rdata : src_q;
	assign run_copy = mov_edge_q ? (mov_exec_q && !mov_prev_q) : mov_exec_q;

	// Control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_exec_q <= 1'b0;
			mov_exec_q <= 1'b0;
			mov_edge_q <= 1'b0;
			src_ind_q <= 1'b0;
		end else if (ctrl_wr) begin
			cmp_exec_q <= pwdata[`CMX_CTRL_CMP_EXEC];
			mov_exec_q <= pwdata[`CMX_CTRL_MOV_EXEC];
			mov_edge_q <= pwdata[`CMX_CTRL_MOV_EDGE];
			src_ind_q <= pwdata[`CMX_CTRL_SRC_IND];
		end
	end

	// Scan start pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_q <= 1'b0;
		end else begin
			go_q <= ctrl_wr && pwdata[`CMX_CTRL_GO] && !busy;
		end
	end

	// Operand registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_compare_word_q <= `CMX_WORD_RST;
			second_compare_word_q <= `CMX_WORD_RST;
			src_q <= `CMX_WORD_RST;
		end else if (wr_en) begin
			if (hit(paddr, `CMX_OFF_CMPA)) begin
				first_compare_word_q <= pwdata[15:0];
			end else if (hit(paddr, `CMX_OFF_CMPB)) begin
				second_compare_word_q <= pwdata[15:0];
			end else if (hit(paddr, `CMX_OFF_SRC)) begin
				src_q <= pwdata[15:0];
			end
		end
	end

	// Indirect pointer register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_q <= `CMX_WORD_RST;
		end else if (wr_en && hit(paddr, `CMX_OFF_PTR)) begin
			ptr_q <= pwdata[15:0];
		end
	end

	// Highest valid pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_limit_q <= `CMX_MEM_LIMIT_RST;
		end else if (wr_en && hit(paddr, `CMX_OFF_LIMIT)) begin
			mem_limit_q <= pwdata[15:0];
		end
	end

	// Scan sequencer: fetch waits one cycle for memory read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= CMX_IDLE;
		end else begin
			case (state_q)
				CMX_IDLE: begin
					if (go_q) begin
						state_q <= CMX_FETCH;
					end
				end
				CMX_FETCH: begin
					state_q <= CMX_EXEC;
				end
				CMX_EXEC: begin
					state_q <= CMX_IDLE;
				end
				default: begin
					state_q <= CMX_IDLE;
				end
			endcase
		end
	end

	// Previous copy condition, sampled once per scan
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mov_prev_q <= 1'b0;
		end else if (state_q == CMX_EXEC) begin
			mov_prev_q <= mov_exec_q;
		end
	end

	// Unsigned three-way compare: exactly one result bit is set
	function automatic logic [2:0] compare3(input cmx_word_t a, input cmx_word_t b);
		if (a > b) begin
			compare3 = 3'b001;
		end else if (a == b) begin
			compare3 = 3'b010;
		end else begin
			compare3 = 3'b100;
		end
	endfunction : compare3

	// Scan execution strobes
	logic [2:0] cmp_res;
	logic scan_run;
	logic cmp_run;
	logic copy_run;
	assign cmp_res = compare3(first_compare_word_q, second_compare_word_q);
	assign scan_run = state_q == CMX_EXEC;
	assign cmp_run = scan_run && cmp_exec_q;
	assign copy_run = scan_run && run_copy && !ptr_bad;

	// Destination word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dest_word <= `CMX_WORD_RST;
		end else if (copy_run) begin
			dest_word <= operand;
		end
	end

	// Greater flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			greater_flag <= 1'b0;
		end else if (cmp_run) begin
			greater_flag <= cmp_res[0];
		end
	end

	// Less flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			less_flag <= 1'b0;
		end else if (cmp_run) begin
			less_flag <= cmp_res[2];
		end
	end

	// Equal flag; copy and compare run in the same cycle and copy takes priority
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			equal_flag <= 1'b0;
		end else if (copy_run) begin
			equal_flag <= operand == 16'h0000;
		end else if (cmp_run) begin
			equal_flag <= cmp_res[1];
		end
	end

	// Error flag, rewritten on every executed scan
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			error_flag <= 1'b0;
		end else if (scan_run) begin
			error_flag <= (cmp_exec_q || run_copy) && ptr_bad;
		end
	end

	// Read data, loaded in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			if (hit(paddr, `CMX_OFF_CTRL)) begin
				prdata <= {27'h0, 1'b0, src_ind_q, mov_edge_q, mov_exec_q, cmp_exec_q};
			end else if (hit(paddr, `CMX_OFF_CMPA)) begin
				prdata <= zext(first_compare_word_q);
			end else if (hit(paddr, `CMX_OFF_CMPB)) begin
				prdata <= zext(second_compare_word_q);
			end else if (hit(paddr, `CMX_OFF_SRC)) begin
				prdata <= zext(src_q);
			end else if (hit(paddr, `CMX_OFF_PTR)) begin
				prdata <= zext(ptr_q);
			end else if (hit(paddr, `CMX_OFF_DEST)) begin
				prdata <= zext(dest_word);
			end else if (hit(paddr, `CMX_OFF_FLAGS)) begin
				prdata <= {27'h0, busy, error_flag, less_flag, equal_flag, greater_flag};
			end else if (hit(paddr, `CMX_OFF_LIMIT)) begin
				prdata <= zext(mem_limit_q);
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end
endmodule : cmx_top

// ==== cmx_chk.sv ====
// Assertion checker for the compare and move executor
`timescale 1ns/1ps
module cmx_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Results
	input wire logic greater_flag,
	input wire logic equal_flag,
	input wire logic less_flag,
	input wire logic error_flag,
	input wire cmx_pkg::cmx_word_t dest_word
);
	import cmx_pkg::*;
	logic [3:0] idle_q;
	logic acc;
	logic rd;
	assign acc = psel && penable;
	assign rd = acc && !pwrite && idle_q > 4'h5;
	// Cycles since the last scan start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			idle_q <= 4'hf;
		else if (acc && pwrite && paddr == 12'h000 && pwdata[4])
			idle_q <= 4'h0;
		else if (idle_q != 4'hf)
			idle_q <= idle_q + 4'h1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_one; !(greater_flag && less_flag); endproperty
	property p_fhold; idle_q > 4'h5 |-> $stable({greater_flag, equal_flag, less_flag, error_flag}); endproperty
	property p_dhold; idle_q > 4'h5 |-> $stable(dest_word); endproperty
	property p_frd; rd && paddr == 12'h018 |-> prdata == {28'h0, error_flag, less_flag, equal_flag, greater_flag};
	endproperty
	property p_drd; rd && paddr == 12'h014 |-> prdata == {16'h0, dest_word}; endproperty
	property p_bad; acc && (paddr > 12'h01f || paddr[1:0] != 2'b00) |-> pslverr; endproperty
	property p_good; acc && paddr < 12'h020 && paddr[1:0] == 2'b00 |-> !pslverr; endproperty
	property p_rdy; psel |-> pready; endproperty
	a_one: assert property (p_one) else $error("greater and less both set");
	a_fhold: assert property (p_fhold) else $error("flags moved without a scan");
	a_dhold: assert property (p_dhold) else $error("destination moved without a scan");
	a_frd: assert property (p_frd) else $error("flag read differs from flag pins");
	a_drd: assert property (p_drd) else $error("destination read differs");
	a_bad: assert property (p_bad) else $error("no slave error on bad address");
	a_good: assert property (p_good) else $error("slave error on good address");
	a_rdy: assert property (p_rdy) else $error("ready low");
	c_gr: cover property (greater_flag);
	c_le: cover property (less_flag);
	c_er: cover property (error_flag);
endmodule : cmx_chk
bind cmx_top cmx_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .greater_flag, .equal_flag, .less_flag, .error_flag, .dest_word);

// ==== test_compare_move_executor.sv ====
// Testbench for the compare and move executor
`timescale 1ns/1ps
module test_compare_move_executor;
	import cmx_pkg::*;
	localparam logic [15:0] CA [5] = '{16'h0005, 16'h0003, 16'h0003, 16'hffff, 16'h0000};
	localparam logic [15:0] CB [5] = '{16'h0003, 16'h0003, 16'h0005, 16'h0001, 16'hffff};
	localparam logic [31:0] CF [5] = '{32'h1, 32'h2, 32'h4, 32'h1, 32'h4};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, serr, greater_flag, equal_flag, less_flag, error_flag;
	cmx_word_t dest_word;
	int miscompares = 0;
	int num_checks = 0;
	always #12.5 pclk = ~pclk;
	cmx_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.greater_flag, .equal_flag, .less_flag, .error_flag, .dest_word);
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(r, exp);
	endtask : rc
	// Start a scan, then poll until it is done; r holds the flags
	task automatic scan(input logic [3:0] c);
		xfer(1'b1, 12'h000, {27'h0, 1'b1, c});
		repeat (2) @(posedge pclk);
		do xfer(1'b0, 12'h018, 32'h0); while (r[4] !== 1'b0);
	endtask : scan
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rc(12'h018, 32'h0);
		rc(12'h014, 32'h0);
		rc(12'h01c, 32'h1fff);
		for (int i = 0; i < 5; i++) begin
			xfer(1'b1, 12'h004, {16'h0, CA[i]});
			xfer(1'b1, 12'h008, {16'h0, CB[i]});
			scan(4'h1);
			chk(r, CF[i]);
			chk({28'h0, error_flag, less_flag, equal_flag, greater_flag}, CF[i]);
		end
		xfer(1'b1, 12'h004, 32'h9);
		scan(4'h0);
		chk(r, 32'h4);
		xfer(1'b1, 12'h00c, 32'h1234);
		scan(4'h2);
		chk(r, 32'h4);
		rc(12'h014, 32'h1234);
		chk({16'h0, dest_word}, 32'h1234);
		xfer(1'b1, 12'h00c, 32'h0);
		scan(4'h2);
		chk(r, 32'h6);
		xfer(1'b1, 12'h00c, 32'h77);
		scan(4'h0);
		rc(12'h014, 32'h0);
		scan(4'h6);
		rc(12'h014, 32'h77);
		xfer(1'b1, 12'h00c, 32'h99);
		scan(4'h6);
		rc(12'h014, 32'h77);
		xfer(1'b1, 12'h014, 32'h8005beef);
		xfer(1'b1, 12'h010, 32'h5);
		scan(4'ha);
		chk(r, 32'h4);
		rc(12'h014, 32'hbeef);
		xfer(1'b1, 12'h010, 32'h000a);
		scan(4'ha);
		chk(r, 32'hc);
		xfer(1'b1, 12'h010, 32'h0070);
		scan(4'ha);
		chk(r, 32'hc);
		xfer(1'b1, 12'h01c, 32'h4);
		xfer(1'b1, 12'h010, 32'h5);
		scan(4'ha);
		chk(r, 32'hc);
		rc(12'h014, 32'hbeef);
		xfer(1'b1, 12'h004, 32'h3);
		xfer(1'b1, 12'h008, 32'h3);
		scan(4'h3);
		chk(r, 32'h0);
		rc(12'h014, 32'h99);
		xfer(1'b0, 12'h020, 32'h0);
		chk({31'h0, serr}, 32'h1);
		summarize();
	end
	initial begin
		repeat (5000) @(posedge pclk);
		miscompares++;
		summarize();
	end
endmodule : test_compare_move_executor
